//--- include/tmrtsc_regs.svh
// register indices, field positions and reset values of the timer start/source control block
// assumes an APB slave where the byte address of a register is four times its index
`ifndef TMRTSC_REGS_SVH
`define TMRTSC_REGS_SVH

// ****************************************************************
// register indices (byte address = index * 4)
// ****************************************************************
`define TMRTSC_IDX_START    10'h380
`define TMRTSC_IDX_ONESHOT  10'h382
`define TMRTSC_IDX_SRCSEL   10'h383
`define TMRTSC_IDX_POL      10'h390
`define TMRTSC_IDX_FREE     10'h391
`define TMRTSC_IDX_RELOAD   10'h3A0
`define TMRTSC_IDX_COUNT    10'h3B0

// ****************************************************************
// fields and reset values
// ****************************************************************
`define TMRTSC_A0SEL_LSB    6
`define TMRTSC_NUM_A        5
`define TMRTSC_NUM_T        8
`define TMRTSC_START_RST    8'h00
`define TMRTSC_SEL_RST      8'h00
`define TMRTSC_A0SEL_RST    2'h0
`define TMRTSC_CNT_MAX      16'hFFFF
`define TMRTSC_CNT_ZERO     16'h0000
`define TMRTSC_RELOAD_RST   16'hFFFF

`endif

//--- include/tmrtsc_pkg.sv
// types shared by the timer start/source control block
// assumes tmrtsc_regs.svh for the numeric constants
package tmrtsc_pkg;

  // event source choice of one A timer
  typedef enum logic [1:0] {
    TMRTSC_SRC_PIN  = 2'b00,
    TMRTSC_SRC_B2   = 2'b01,
    TMRTSC_SRC_PREV = 2'b10,
    TMRTSC_SRC_NEXT = 2'b11
  } tmrtsc_src_e;

  typedef logic [15:0] tmrtsc_cnt_t;

endpackage

//--- src/tmrtsc_src_sel.sv
// event source selector of one A timer: pin edge or a neighbour's overflow pulse
// assumes pin_lvl is already synchronised to pclk and overflow inputs are one-cycle pulses
`timescale 1ns/100ps
module tmrtsc_src_sel #(
  parameter bit HAS_B2 = 1'b1
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  pin_lvl,
  input  wire logic                  b2_ovf,
  input  wire logic                  prev_ovf,
  input  wire logic                  next_ovf,
  input  wire tmrtsc_pkg::tmrtsc_src_e sel,
  input  wire logic                  rise_sel,
  output logic                       evt
);
  import tmrtsc_pkg::*;

  logic pin_prev_r;
  logic pin_prev_nxt;
  logic pin_edge;

  always_comb begin
    pin_prev_nxt = pin_lvl;
    // polarity 0 counts falling edges, 1 rising edges
    pin_edge     = rise_sel ? (pin_lvl & ~pin_prev_r) : (~pin_lvl & pin_prev_r);
    case (sel)
      TMRTSC_SRC_PIN:  evt = pin_edge;
      // timer a4 has no b2 choice; that code gives no events
      TMRTSC_SRC_B2:   evt = HAS_B2 ? b2_ovf : 1'b0;
      TMRTSC_SRC_PREV: evt = prev_ovf;
      TMRTSC_SRC_NEXT: evt = next_ovf;
      default:         evt = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_r <= 1'b0;
    end else begin
      pin_prev_r <= pin_prev_nxt;
    end
  end

endmodule // tmrtsc_src_sel

//--- src/tmrtsc_top.sv
// start/stop flags for eight 16-bit timers, one-shot starts and event source selection for the five A timers
// assumes an APB master on pclk; external event pins are asynchronous to pclk
//
// What this block does
// - Writing 1 to an A timer one-shot start bit starts that timer; those bits read as 0.
// - Timer a0 source: 00 its pin, 01 b2 overflow, 10 a4 overflow, 11 a1 overflow.
// - Timer a1 source: 00 its pin, 01 b2 overflow, 10 a0 overflow, 11 a2 overflow.
// - Timer a2 source sits in bits 3:2: 00 its pin, 01 b2, 10 a1, 11 a3 overflow.
// - Timer a3 source: 00 its pin, 01 b2 overflow, 10 a2 overflow, 11 a4 overflow.
// - Timer a4 source: 00 its pin, 10 a3 overflow, 11 a0 overflow.
// - Eight run bits, a0..a4 in bits 0..4 and b0..b2 in 5..7, stop at 0, run at 1, reset 0.
// - In event counting a polarity bit of 0 counts falling pin edges and 1 rising edges.
// - A type bit of 0 reloads on underflow, 1 lets the counter run free.
`timescale 1ns/100ps
`include "tmrtsc_regs.svh"
module tmrtsc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [4:0]  ext_in_pin,
  output logic [7:0]       count_run,
  output logic [4:0]       one_shot_pulse,
  output logic [7:0]       ovf_pulse
);
  import tmrtsc_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]  start_r,    start_nxt;
  logic [1:0]  a0_sel_r,   a0_sel_nxt;
  logic [7:0]  srcsel_r,   srcsel_nxt;
  logic [7:0]  pol_r,      pol_nxt;
  logic [7:0]  free_r,     free_nxt;
  logic [4:0]  oneshot_r,  oneshot_nxt;
  logic [7:0]  ovf_r,      ovf_nxt;
  logic        pready_r,   pready_nxt;
  logic        pslverr_r,  pslverr_nxt;
  logic [31:0] prdata_r,   prdata_nxt;
  logic [4:0]  pin_s1_r;
  logic [4:0]  pin_s2_r;
  tmrtsc_cnt_t cnt_r      [`TMRTSC_NUM_T];
  tmrtsc_cnt_t cnt_nxt    [`TMRTSC_NUM_T];
  tmrtsc_cnt_t reload_r   [`TMRTSC_NUM_T];
  tmrtsc_cnt_t reload_nxt [`TMRTSC_NUM_T];
  logic [4:0]  a_evt;
  logic [7:0]  evt_all;
  logic [1:0]  a_sel      [`TMRTSC_NUM_A];
  logic [9:0]  idx;
  logic        wr_en;
  logic        setup;

  function automatic logic [9:0] word_idx(input logic [11:0] addr);
    word_idx = addr[11:2];
  endfunction

  function automatic logic hit_arr(input logic [9:0] i, input logic [9:0] base,
                                   input int n);
    hit_arr = (i == (base + 10'(n)));
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 5'h0;
      pin_s2_r <= 5'h0;
    end else begin
      pin_s1_r <= ext_in_pin;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ****************************************************************
  // source selection of the A timers
  // ****************************************************************
  assign a_sel[0] = a0_sel_r;
  assign a_sel[1] = srcsel_r[1:0];
  assign a_sel[2] = srcsel_r[3:2];
  assign a_sel[3] = srcsel_r[5:4];
  assign a_sel[4] = srcsel_r[7:6];

  // neighbours wrap around the ring a0..a4, which gives every mapping above
  for (genvar g = 0; g < `TMRTSC_NUM_A; g++) begin : g_src
    tmrtsc_src_sel #(
      .HAS_B2 (g != `TMRTSC_NUM_A - 1)
    ) u_src (
      .pclk     (pclk),
      .presetn  (presetn),
      .pin_lvl  (pin_s2_r[g]),
      .b2_ovf   (ovf_r[7]),
      .prev_ovf (ovf_r[(g + `TMRTSC_NUM_A - 1) % `TMRTSC_NUM_A]),
      .next_ovf (ovf_r[(g + 1) % `TMRTSC_NUM_A]),
      .sel      (tmrtsc_src_e'(a_sel[g])),
      .rise_sel (pol_r[g]),
      .evt      (a_evt[g])
    );
  end

  // b timers count every pclk
  assign evt_all = {3'b111, a_evt};

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    idx         = word_idx(paddr);
    setup       = psel & ~penable;
    wr_en       = psel & penable & pready_r & pwrite;
    start_nxt   = start_r;
    a0_sel_nxt  = a0_sel_r;
    srcsel_nxt  = srcsel_r;
    pol_nxt     = pol_r;
    free_nxt    = free_r;
    oneshot_nxt = 5'h0;
    ovf_nxt     = 8'h0;
    pready_nxt  = setup;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    for (int i = 0; i < `TMRTSC_NUM_T; i++) begin
      reload_nxt[i] = reload_r[i];
      cnt_nxt[i]    = cnt_r[i];
      // a stopped timer ignores its events and keeps its count
      if (start_r[i] && evt_all[i]) begin
        if (cnt_r[i] == `TMRTSC_CNT_ZERO) begin
          ovf_nxt[i] = 1'b1;
          cnt_nxt[i] = free_r[i] ? `TMRTSC_CNT_MAX : reload_r[i];
        end else begin
          cnt_nxt[i] = cnt_r[i] - 16'h0001;
        end
      end
    end
    if (wr_en) begin
      case (idx)
        `TMRTSC_IDX_START:  start_nxt = pwdata[7:0];
        `TMRTSC_IDX_ONESHOT: begin
          a0_sel_nxt = pwdata[`TMRTSC_A0SEL_LSB +: 2];
          // the unused bit is not stored, whatever software writes
          for (int i = 0; i < `TMRTSC_NUM_A; i++) begin
            if (pwdata[i]) begin
              oneshot_nxt[i] = 1'b1;
              cnt_nxt[i]     = reload_r[i];
              start_nxt[i]   = 1'b1;
            end
          end
        end
        `TMRTSC_IDX_SRCSEL: srcsel_nxt = pwdata[7:0];
        `TMRTSC_IDX_POL:    pol_nxt    = pwdata[7:0];
        `TMRTSC_IDX_FREE:   free_nxt   = pwdata[7:0];
        default: begin
          for (int i = 0; i < `TMRTSC_NUM_T; i++) begin
            if (hit_arr(idx, `TMRTSC_IDX_RELOAD, i)) begin
              reload_nxt[i] = pwdata[15:0];
              // a stopped timer also takes the value, so it starts from it
              if (!start_r[i]) begin
                cnt_nxt[i] = pwdata[15:0];
              end
            end
          end
        end
      endcase
    end
    // read data is prepared in the setup cycle so it stands out of a flop
    if (setup) begin
      prdata_nxt  = 32'h0;
      pslverr_nxt = 1'b1;
      case (idx)
        `TMRTSC_IDX_START: begin
          prdata_nxt[7:0] = start_r;
          pslverr_nxt     = 1'b0;
        end
        `TMRTSC_IDX_ONESHOT: begin
          // start bits and the unused bit read 0
          prdata_nxt[`TMRTSC_A0SEL_LSB +: 2] = a0_sel_r;
          pslverr_nxt                        = 1'b0;
        end
        `TMRTSC_IDX_SRCSEL: begin
          prdata_nxt[7:0] = srcsel_r;
          pslverr_nxt     = 1'b0;
        end
        `TMRTSC_IDX_POL: begin
          prdata_nxt[7:0] = pol_r;
          pslverr_nxt     = 1'b0;
        end
        `TMRTSC_IDX_FREE: begin
          prdata_nxt[7:0] = free_r;
          pslverr_nxt     = 1'b0;
        end
        default: begin
          for (int i = 0; i < `TMRTSC_NUM_T; i++) begin
            if (hit_arr(idx, `TMRTSC_IDX_RELOAD, i)) begin
              prdata_nxt[15:0] = reload_r[i];
              pslverr_nxt      = 1'b0;
            end
            if (hit_arr(idx, `TMRTSC_IDX_COUNT, i)) begin
              prdata_nxt[15:0] = cnt_r[i];
              pslverr_nxt      = 1'b0;
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r   <= `TMRTSC_START_RST;
      a0_sel_r  <= `TMRTSC_A0SEL_RST;
      srcsel_r  <= `TMRTSC_SEL_RST;
      pol_r     <= `TMRTSC_SEL_RST;
      free_r    <= `TMRTSC_SEL_RST;
      oneshot_r <= 5'h0;
      ovf_r     <= 8'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
      for (int i = 0; i < `TMRTSC_NUM_T; i++) begin
        cnt_r[i]    <= `TMRTSC_CNT_ZERO;
        reload_r[i] <= `TMRTSC_RELOAD_RST;
      end
    end else begin
      start_r   <= start_nxt;
      a0_sel_r  <= a0_sel_nxt;
      srcsel_r  <= srcsel_nxt;
      pol_r     <= pol_nxt;
      free_r    <= free_nxt;
      oneshot_r <= oneshot_nxt;
      ovf_r     <= ovf_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
      for (int i = 0; i < `TMRTSC_NUM_T; i++) begin
        cnt_r[i]    <= cnt_nxt[i];
        reload_r[i] <= reload_nxt[i];
      end
    end
  end

  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign prdata         = prdata_r;
  assign count_run      = start_r;
  assign one_shot_pulse = oneshot_r;
  assign ovf_pulse      = ovf_r;

endmodule // tmrtsc_top

//--- dv/tmrtsc_monitor.sv
// concurrent checks on the ports of the timer start/source control block
// assumes the register indices of tmrtsc_regs.svh and a zero-wait apb slave
`timescale 1ns/100ps
`include "tmrtsc_regs.svh"
module tmrtsc_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [7:0]  count_run,
  input wire logic [4:0]  one_shot_pulse,
  input wire logic [7:0]  ovf_pulse
);
  localparam logic [11:0] START_A = {`TMRTSC_IDX_START, 2'b00};
  localparam logic [11:0] OS_A    = {`TMRTSC_IDX_ONESHOT, 2'b00};
  // ****************************************************************
  // last value written to the run flags
  // ****************************************************************
  wire        acc = psel && penable && pready;
  logic [7:0] start_r;
  logic [7:0] start_nxt;
  always_comb begin
    start_nxt = start_r;
    if (acc && pwrite && paddr == START_A) start_nxt = pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) start_r <= 8'h00;
    else start_r <= start_nxt;
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr(a);
    acc && pwrite && !pslverr && paddr == a;
  endsequence
  AST_APB_READY: assert property (s_setup |=> pready) else $error("no ready after setup");
  AST_APB_PULSE: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  AST_ERR_READY: assert property (pslverr |-> pready && prdata == 32'h00000000)
    else $error("error without ready or with data");
  AST_START_COPY: assert property (s_wr(START_A) |-> ##2 (count_run == start_r))
    else $error("run flags differ from written value");
  AST_OS_PULSE: assert property ((s_wr(OS_A) ##0 (pwdata[4:0] != 5'h00)) |->
    ##[1:2] (one_shot_pulse != 5'h00)) else $error("one-shot start gave no pulse");
  AST_OS_NONE: assert property ((s_wr(OS_A) ##0 (pwdata[4:0] == 5'h00)) |=>
    (one_shot_pulse == 5'h00) [*2]) else $error("one-shot pulse without a start bit");
  AST_OS_ONE: assert property ((one_shot_pulse != 5'h00) |=> (one_shot_pulse == 5'h00))
    else $error("one-shot pulse too long");
  AST_OVF_ONE: assert property ((ovf_pulse[4:0] & $past(ovf_pulse[4:0])) == 5'h00)
    else $error("overflow pulse too long");
  // a stopped timer never overflows; two cycles of slack cover the registered overflow pulse
  AST_STOP_QUIET: assert property ((ovf_pulse[4:0] & ~(count_run[4:0] |
    $past(count_run[4:0]) | $past(count_run[4:0], 2))) == 5'h00)
    else $error("stopped timer overflowed");
  cover property (s_wr(OS_A));
endmodule // tmrtsc_monitor
bind tmrtsc_top tmrtsc_monitor tmrtsc_monitor_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .count_run(count_run),
  .one_shot_pulse(one_shot_pulse), .ovf_pulse(ovf_pulse));

//--- dv/tmrtsc_pin_model.sv
// external event pins of the five A timers
// assumes the bench asks for a toggle with a one-cycle request per pin
`timescale 1ns/100ps
module tmrtsc_pin_model (
  input wire logic       pclk,
  input wire logic [4:0] tgl,
  output logic     [4:0] ext_in_pin
);
  // pins idle low so no edge is seen out of reset
  initial ext_in_pin = 5'h00;
  always @(posedge pclk) ext_in_pin <= ext_in_pin ^ tgl;
endmodule // tmrtsc_pin_model

//--- dv/tb_tmrtsc_top.sv
// self-checking bench of the timer start/source control block
// assumes tmrtsc_top, the pin model and the bound monitor are compiled before it
`timescale 1ns/100ps
`include "tmrtsc_regs.svh"
module tb_tmrtsc_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  tgl, pins, os_pulse, os_seen;
  logic [7:0]  run, ovf;
  int          err_total, n_tests, cyc;
  int          ovf_cnt [8];
  int          tgt [10] = '{0, 0, 1, 1, 2, 2, 3, 3, 4, 4};
  int          cod [10] = '{2, 3, 2, 3, 2, 3, 2, 3, 2, 3};
  int          src [10] = '{4, 1, 0, 2, 1, 3, 2, 4, 3, 0};
  tmrtsc_top tmrtsc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .ext_in_pin(pins), .count_run(run), .one_shot_pulse(os_pulse),
    .ovf_pulse(ovf));
  tmrtsc_pin_model tmrtsc_pin_model_inst (.pclk(pclk), .tgl(tgl), .ext_in_pin(pins));
  // ****************************************************************
  // clock, watchdog and pulse capture
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    os_seen = os_seen | os_pulse;
    foreach (ovf_cnt[k]) ovf_cnt[k] += (ovf[k] === 1'b1) ? 1 : 0;
    if (cyc == 30000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic tally_and_finish();
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask
  // holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h00000000);
    chk(nm, rd, exp);
  endtask
  task automatic pin_tgl(input int j);
    @(posedge pclk);
    tgl <= 5'(1 << j);
    @(posedge pclk);
    tgl <= 5'h00;
    repeat (8) @(posedge pclk);
  endtask
  task automatic pin_edge(input int j);
    pin_tgl(j);
    pin_tgl(j);
  endtask
  // every other A timer falls back to its pin; bit 5 is always written 0
  task automatic set_sel(input int i, input int c);
    apb(1'b1, `TMRTSC_IDX_ONESHOT, (i == 0) ? 32'(c << 6) : 32'h0);
    apb(1'b1, `TMRTSC_IDX_SRCSEL, (i == 0) ? 32'h0 : 32'(c << (2 * (i - 1))));
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, tgl, os_seen} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdc("start rst", `TMRTSC_IDX_START, 32'h0);
    rdc("srcsel rst", `TMRTSC_IDX_SRCSEL, 32'h0);
    apb(1'b1, `TMRTSC_IDX_START, 32'hA5);
    rdc("start rw", `TMRTSC_IDX_START, 32'hA5);
    chk("run", 32'(run), 32'hA5);
    apb(1'b0, 10'h3FF, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    apb(1'b1, `TMRTSC_IDX_START, 32'h0);
    for (int i = 0; i < 5; i++) apb(1'b1, 10'(`TMRTSC_IDX_RELOAD + i), 32'h0);
    apb(1'b1, `TMRTSC_IDX_POL, 32'h1F);
    apb(1'b1, `TMRTSC_IDX_START, 32'h1F);
    for (int e = 0; e < 10; e++) begin
      set_sel(tgt[e], cod[e]);
      foreach (ovf_cnt[k]) ovf_cnt[k] = 0;
      pin_edge(src[e]);
      chk("ring ovf", 32'(ovf_cnt[tgt[e]]), 32'h1);
    end
    // b2 restarts from 0x10, so it underflows once in the window; a4 has no b2 choice
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `TMRTSC_IDX_START, 32'h0);
      apb(1'b1, 10'(`TMRTSC_IDX_RELOAD + 7), 32'h10);
      set_sel(i, 1);
      foreach (ovf_cnt[k]) ovf_cnt[k] = 0;
      apb(1'b1, `TMRTSC_IDX_START, 32'(8'h80 | (1 << i)));
      repeat (20) @(posedge pclk);
      chk("b2 self ovf", 32'(ovf_cnt[7]), 32'h1);
      chk("b2 ovf", 32'(ovf_cnt[i]), (i == 4) ? 32'h0 : 32'h1);
    end
    apb(1'b1, `TMRTSC_IDX_START, 32'h1F);
    set_sel(1, 0);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, `TMRTSC_IDX_POL, p ? 32'h1F : 32'h0);
      foreach (ovf_cnt[k]) ovf_cnt[k] = 0;
      pin_tgl(2);
      chk("rise", 32'(ovf_cnt[2]), 32'(p));
      pin_tgl(2);
      chk("fall", 32'(ovf_cnt[2]), 32'h1);
    end
    for (int f = 0; f < 2; f++) begin
      apb(1'b1, `TMRTSC_IDX_START, 32'h0);
      apb(1'b1, 10'(`TMRTSC_IDX_RELOAD + 3), 32'h0);
      apb(1'b1, `TMRTSC_IDX_FREE, 32'(f << 3));
      apb(1'b1, `TMRTSC_IDX_START, 32'h1F);
      pin_edge(3);
      rdc("free", 10'(`TMRTSC_IDX_COUNT + 3), f ? 32'hFFFF : 32'h0);
    end
    apb(1'b1, `TMRTSC_IDX_START, 32'h0);
    apb(1'b1, 10'(`TMRTSC_IDX_RELOAD + 2), 32'h4);
    pin_edge(2);
    rdc("held", 10'(`TMRTSC_IDX_COUNT + 2), 32'h4);
    apb(1'b1, `TMRTSC_IDX_START, 32'h04);
    pin_edge(2);
    rdc("resumed", 10'(`TMRTSC_IDX_COUNT + 2), 32'h3);
    apb(1'b1, `TMRTSC_IDX_START, 32'h0);
    for (int i = 0; i < 5; i++) begin
      os_seen = 5'h00;
      apb(1'b1, `TMRTSC_IDX_ONESHOT, 32'(1 << i));
      repeat (3) @(posedge pclk);
      chk("one-shot pulse", 32'(os_seen), 32'(1 << i));
      chk("one-shot run", 32'(run[i]), 32'h1);
    end
    apb(1'b1, `TMRTSC_IDX_ONESHOT, 32'hC0);
    rdc("one-shot read", `TMRTSC_IDX_ONESHOT, 32'hC0);
    tally_and_finish();
  end
endmodule // tb_tmrtsc_top
